/* File: hdl/emsz_top.sv */
/*
 * emsz_top: terminus-side event message buffer-size negotiation and
 * sensor-class event data generation, with an APB register slave.
 * Assumes an APB3 master on pclk; ev_ready comes from the message transport.
 */
// Local design decisions: the address map and register access over APB.
// Summary of operation
// - the terminus implements the buffer-size negotiation command
// - negotiated size is the smaller of receiver and terminus maxima
// - oversized event sends a poll notification instead of the message
// - without negotiation the size is 256 bytes
// - sizes count protocol header and payload, no transport header
// - response is 8-bit completion code then 16-bit terminus maximum
// - the size limit covers pushed messages only, not polled ones
// - event data opens with the 16-bit sensor identifier
// - an 8-bit sub-class byte follows the identifier
// - numeric-sensor events carry the triggering reading
// - state-sensor events carry a member byte, 0 to 7
// - the member byte is followed by the new state
// - unknown previous state is reported equal to the new state
`timescale 1ns/10ps
module emsz_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             ev_valid,
	output logic [7:0]       ev_data,
	input  wire logic        ev_ready,
	output logic             poll_evt,
	output logic [15:0]      neg_size,
	output logic             irq
);
	logic [15:0] rx_reg, rx_next, tx_reg, tx_next, base_reg, base_next;
	logic [15:0] size_reg, size_next;
	logic [23:0] resp_reg, resp_next;
	logic [31:0] sens_reg, sens_next, st_reg, st_next, rd_reg, rd_next;
	localparam int I_W_BITS = emsz_pkg::I_W;

	logic [I_W_BITS-1:0] stat_reg, stat_next, mask_reg, mask_next;
	logic        nego_reg, nego_next, poll_reg, poll_next, start_reg, start_next;
	logic [31:0] prdata_reg, prdata_next;

	logic        wr, rd_setup, mapped, neg_fire, ev_fire, too_big;
	logic        fmt_busy, fmt_done;
	logic [15:0] neg_min, msg_len;
	emsz_pkg::emsz_event_type ev_cur;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	function automatic logic is_mapped(input logic [7:0] a);
		return a <= emsz_pkg::A_STATUS && a[1:0] == 2'b00;
	endfunction : is_mapped

	assign mapped   = is_mapped(paddr);
	assign wr       = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = penable;
	assign pslverr  = psel && penable && !mapped;

	assign neg_fire = wr && paddr == emsz_pkg::A_CTRL && pwdata[emsz_pkg::F_CTRL_NEG];
	assign ev_fire  = wr && paddr == emsz_pkg::A_CTRL && pwdata[emsz_pkg::F_CTRL_EVT]
		&& !fmt_busy && !start_reg;

	// sizes held here count header and payload only, so they compare directly
	assign neg_min  = (rx_reg < tx_reg) ? rx_reg : tx_reg;

	////////////////////////////////////////////////////////////////////////
	// event record assembly

	always_comb begin
		ev_cur           = '0;
		ev_cur.sensor_id = sens_reg[15:0];
		case (sens_reg[emsz_pkg::F_CLS_LSB +: 2])
			2'd1:    ev_cur.sub = emsz_pkg::SC_SENSOR_STATE;
			2'd2:    ev_cur.sub = emsz_pkg::SC_NUMERIC;
			default: ev_cur.sub = emsz_pkg::SC_OP_STATE;
		endcase
		ev_cur.offset  = sens_reg[emsz_pkg::F_OFS_LSB +: 3];
		ev_cur.state   = st_reg[7:0];
		ev_cur.prev    = st_reg[emsz_pkg::F_PKN] ? st_reg[15:8] : st_reg[7:0];
		ev_cur.dsize   = st_reg[emsz_pkg::F_DSZ_LSB +: 8];
		ev_cur.reading = rd_reg;
	end

	assign msg_len = 16'(base_reg + {12'h000, emsz_pkg::ev_len(ev_cur)});
	assign too_big = msg_len > size_reg;

	////////////////////////////////////////////////////////////////////////
	// register next state

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		if (a == emsz_pkg::A_RXSIZE) begin
			return {16'h0000, rx_reg};
		end else if (a == emsz_pkg::A_TXMAX) begin
			return {16'h0000, tx_reg};
		end else if (a == emsz_pkg::A_RESP) begin
			return {8'h00, resp_reg};
		end else if (a == emsz_pkg::A_SENSOR) begin
			return sens_reg;
		end else if (a == emsz_pkg::A_STATE) begin
			return st_reg;
		end else if (a == emsz_pkg::A_READ) begin
			return rd_reg;
		end else if (a == emsz_pkg::A_BASE) begin
			return {16'h0000, base_reg};
		end else if (a == emsz_pkg::A_STAT) begin
			return {29'h0000_0000, stat_reg};
		end else if (a == emsz_pkg::A_MASK) begin
			return {29'h0000_0000, mask_reg};
		end else if (a == emsz_pkg::A_STATUS) begin
			return {14'h0000, size_reg, fmt_busy, nego_reg};
		end
		return emsz_pkg::ZERO32;
	endfunction : rd_mux

	always_comb begin
		rx_next     = rx_reg;
		tx_next     = tx_reg;
		base_next   = base_reg;
		size_next   = size_reg;
		resp_next   = resp_reg;
		sens_next   = sens_reg;
		st_next     = st_reg;
		rd_next     = rd_reg;
		mask_next   = mask_reg;
		stat_next   = stat_reg;
		nego_next   = nego_reg;
		poll_next   = 1'b0;
		start_next  = 1'b0;
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = rd_mux(paddr);
		end
		if (wr) begin
			if (paddr == emsz_pkg::A_RXSIZE) begin
				rx_next = pwdata[15:0];
			end else if (paddr == emsz_pkg::A_TXMAX) begin
				tx_next = pwdata[15:0];
			end else if (paddr == emsz_pkg::A_SENSOR) begin
				sens_next = pwdata;
			end else if (paddr == emsz_pkg::A_STATE) begin
				st_next = pwdata;
			end else if (paddr == emsz_pkg::A_READ) begin
				rd_next = pwdata;
			end else if (paddr == emsz_pkg::A_BASE) begin
				base_next = pwdata[15:0];
			end else if (paddr == emsz_pkg::A_STAT) begin
				stat_next = stat_reg & ~pwdata[I_W_BITS-1:0];
			end else if (paddr == emsz_pkg::A_MASK) begin
				mask_next = pwdata[I_W_BITS-1:0];
			end
		end
		if (neg_fire) begin
			size_next = neg_min;
			resp_next = {tx_reg, emsz_pkg::CC_SUCCESS};
			nego_next = 1'b1;
			stat_next[emsz_pkg::I_NEG] = 1'b1;
		end
		if (ev_fire) begin
			if (too_big) begin
				// receiver must fetch it by polling
				poll_next = 1'b1;
				stat_next[emsz_pkg::I_POLL] = 1'b1;
			end else begin
				start_next = 1'b1;
			end
		end
		if (fmt_done) begin
			stat_next[emsz_pkg::I_SENT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_reg     <= emsz_pkg::DEF_SIZE;
			tx_reg     <= emsz_pkg::TXMAX_RST;
			base_reg   <= emsz_pkg::BASE_RST;
			size_reg   <= emsz_pkg::DEF_SIZE;
			resp_reg   <= 24'h00_0000;
			sens_reg   <= emsz_pkg::ZERO32;
			st_reg     <= emsz_pkg::ZERO32;
			rd_reg     <= emsz_pkg::ZERO32;
			stat_reg   <= '0;
			mask_reg   <= '0;
			nego_reg   <= 1'b0;
			poll_reg   <= 1'b0;
			start_reg  <= 1'b0;
			prdata_reg <= emsz_pkg::ZERO32;
		end else if (pce) begin
			rx_reg     <= rx_next;
			tx_reg     <= tx_next;
			base_reg   <= base_next;
			size_reg   <= size_next;
			resp_reg   <= resp_next;
			sens_reg   <= sens_next;
			st_reg     <= st_next;
			rd_reg     <= rd_next;
			stat_reg   <= stat_next;
			mask_reg   <= mask_next;
			nego_reg   <= nego_next;
			poll_reg   <= poll_next;
			start_reg  <= start_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata   = prdata_reg;
	assign poll_evt = poll_reg;
	assign neg_size = size_reg;
	assign irq      = |(stat_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////
	// formatter

	emsz_fmt u_fmt (
		.pclk     (pclk),
		.presetn  (presetn),
		.pce      (pce),
		.start    (start_reg),
		.ev       (ev_cur),
		.ev_valid (ev_valid),
		.ev_data  (ev_data),
		.ev_ready (ev_ready),
		.busy     (fmt_busy),
		.done     (fmt_done)
	);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// negotiation
	a_neg_min_size: assert property (neg_fire && pce |=> size_reg == $past(neg_min))
		else $error("negotiated size not the minimum");
	a_default_size: assert property (!nego_reg |-> size_reg == emsz_pkg::DEF_SIZE)
		else $error("default size not 256");
	a_resp_format: assert property (neg_fire && pce |=>
		resp_reg[7:0] == emsz_pkg::CC_SUCCESS && resp_reg[23:8] == $past(tx_reg))
		else $error("bad response");
	a_size_held: assert property (!(neg_fire && pce) |=> $stable(size_reg))
		else $error("size changed without negotiation");
	a_resp_held: assert property (!(neg_fire && pce) |=> $stable(resp_reg))
		else $error("response changed without negotiation");

	// event path
	a_poll_instead: assert property (ev_fire && pce && too_big |=>
		poll_evt && !start_reg ##1 !ev_valid)
		else $error("oversized event pushed");
	a_poll_pulse: assert property (poll_evt && pce |=> !poll_evt)
		else $error("poll notice longer than one cycle");
	a_poll_flag: assert property (ev_fire && pce && too_big |=>
		stat_reg[emsz_pkg::I_POLL])
		else $error("poll status not set");
	a_fit_sent: assert property (ev_fire && pce && !too_big |=>
		start_reg && !poll_evt)
		else $error("fitting event not started");
	a_start_idle: assert property (start_reg |-> !fmt_busy)
		else $error("start while formatter busy");
	a_id_first: assert property (start_reg && pce |=>
		ev_valid && ev_data == $past(sens_reg[7:0]))
		else $error("id not first");
	a_prev_fill: assert property (start_reg && pce && !st_reg[emsz_pkg::F_PKN] |->
		ev_cur.prev == st_reg[7:0])
		else $error("unknown prev not filled");
	a_state_after: assert property (ev_cur.sub == emsz_pkg::SC_SENSOR_STATE |->
		ev_cur.state == st_reg[7:0] && emsz_pkg::ev_len(ev_cur) == 4'h6)
		else $error("state record shape wrong");
	a_done_idle: assert property (fmt_done |-> !ev_valid)
		else $error("done while still streaming");
	// a clear written in the same cycle must not lose the sent flag
	a_sent_flag: assert property (fmt_done && pce |=> stat_reg[emsz_pkg::I_SENT])
		else $error("sent status lost");

	// bus and clock enable
	a_freeze_all: assert property (!pce |=> $stable(size_reg) && $stable(stat_reg)
		&& $stable(prdata_reg) && $stable(poll_reg))
		else $error("state moved while frozen");
	a_zero_read: assert property (psel && !penable && !pwrite && pce
		&& (paddr == emsz_pkg::A_CTRL || !mapped) |=> prdata == emsz_pkg::ZERO32)
		else $error("control or unmapped read not zero");
	a_unmapped_write: assert property (psel && penable && pwrite && !mapped && pce
		|=> $stable(rx_reg) && $stable(tx_reg) && $stable(base_reg))
		else $error("unmapped write stored");

	c_negotiate: cover property (neg_fire && pce ##1 nego_reg);
	c_poll: cover property (poll_evt);
	c_sent: cover property (fmt_done && irq);
	c_big_base: cover property (poll_evt && base_reg != 16'h0000);
endmodule : emsz_top

/* File: hdl/emsz_pkg.sv */
/*
 * emsz_pkg: register map, field positions, reset values, types and helper
 * functions shared by the event-size negotiation block and its formatter.
 * Assumes a 32-bit APB bus and byte addresses on paddr[7:0].
 */
package emsz_pkg;
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_RXSIZE = 8'h04;
	localparam logic [7:0]  A_TXMAX  = 8'h08;
	localparam logic [7:0]  A_RESP   = 8'h0C;
	localparam logic [7:0]  A_SENSOR = 8'h10;
	localparam logic [7:0]  A_STATE  = 8'h14;
	localparam logic [7:0]  A_READ   = 8'h18;
	localparam logic [7:0]  A_BASE   = 8'h1C;
	localparam logic [7:0]  A_STAT   = 8'h20;
	localparam logic [7:0]  A_MASK   = 8'h24;
	localparam logic [7:0]  A_STATUS = 8'h28;

	localparam int F_CTRL_NEG = 0;
	localparam int F_CTRL_EVT = 1;
	localparam int F_CLS_LSB  = 16;
	localparam int F_OFS_LSB  = 24;
	localparam int F_DSZ_LSB  = 16;
	localparam int F_PKN      = 24;
	localparam int I_NEG      = 0;
	localparam int I_SENT     = 1;
	localparam int I_POLL     = 2;
	localparam int I_W        = 3;

	localparam logic [15:0] DEF_SIZE   = 16'h0100;
	localparam logic [15:0] TXMAX_RST  = 16'h0400;
	localparam logic [15:0] BASE_RST   = 16'h0000;
	localparam logic [7:0]  CC_SUCCESS = 8'h00;
	localparam logic [31:0] ZERO32     = 32'h0000_0000;

	typedef enum logic [7:0] {
		SC_OP_STATE,
		SC_SENSOR_STATE,
		SC_NUMERIC
	} emsz_class_type;

	typedef struct packed {
		logic [15:0]    sensor_id;
		emsz_class_type sub;
		logic [2:0]     offset;
		logic [7:0]     state;
		logic [7:0]     prev;
		logic [7:0]     dsize;
		logic [31:0]    reading;
	} emsz_event_type;

	// reading width in bytes: uint8/sint8, uint16/sint16, else 32 bits
	function automatic logic [3:0] rd_bytes(input logic [7:0] dsize);
		if (dsize < 8'h02) begin
			return 4'h1;
		end else if (dsize < 8'h04) begin
			return 4'h2;
		end
		return 4'h4;
	endfunction : rd_bytes

	// event data length in bytes
	function automatic logic [3:0] ev_len(input emsz_event_type e);
		case (e.sub)
			SC_SENSOR_STATE: return 4'h6;
			SC_NUMERIC:      return 4'(4'h6 + rd_bytes(e.dsize));
			default:         return 4'h5;
		endcase
	endfunction : ev_len
endpackage : emsz_pkg

/* File: hdl/emsz_fmt.sv */
/*
 * emsz_fmt: serialises one sensor-class event data record as a byte stream
 * with valid/ready, least significant byte first.
 * Assumes the caller starts it only while busy is low.
 */
`timescale 1ns/10ps
module emsz_fmt (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    pce,
	input  wire logic                    start,
	input  wire emsz_pkg::emsz_event_type ev,
	output logic                         ev_valid,
	output logic [7:0]                   ev_data,
	input  wire logic                    ev_ready,
	output logic                         busy,
	output logic                         done
);
	emsz_pkg::emsz_event_type ev_reg, ev_next;
	logic [3:0] idx_reg, idx_next, len_reg, len_next;
	logic       act_reg, act_next, done_reg, done_next;
	logic [7:0] data_reg, data_next;

	function automatic logic [7:0] byte_at(input emsz_pkg::emsz_event_type e,
			input logic [3:0] i);
		logic [7:0] r;
		r = 8'h00;
		if (i == 4'h0) begin
			r = e.sensor_id[7:0];
		end else if (i == 4'h1) begin
			r = e.sensor_id[15:8];
		end else if (i == 4'h2) begin
			r = e.sub;
		end else begin
			case (e.sub)
				emsz_pkg::SC_SENSOR_STATE: begin
					case (i)
						4'h3:    r = {5'h00, e.offset};
						4'h4:    r = e.state;
						default: r = e.prev;
					endcase
				end
				emsz_pkg::SC_NUMERIC: begin
					case (i)
						4'h3:    r = e.state;
						4'h4:    r = e.prev;
						4'h5:    r = e.dsize;
						4'h6:    r = e.reading[7:0];
						4'h7:    r = e.reading[15:8];
						4'h8:    r = e.reading[23:16];
						default: r = e.reading[31:24];
					endcase
				end
				default: r = (i == 4'h3) ? e.state : e.prev;
			endcase
		end
		return r;
	endfunction : byte_at

	always_comb begin
		ev_next   = ev_reg;
		idx_next  = idx_reg;
		len_next  = len_reg;
		act_next  = act_reg;
		data_next = data_reg;
		done_next = 1'b0;
		if (!act_reg && start) begin
			ev_next   = ev;
			idx_next  = 4'h0;
			len_next  = emsz_pkg::ev_len(ev);
			act_next  = 1'b1;
			data_next = byte_at(ev, 4'h0);
		end else if (act_reg && ev_ready) begin
			if (4'(idx_reg + 4'h1) == len_reg) begin
				act_next  = 1'b0;
				done_next = 1'b1;
			end else begin
				idx_next  = 4'(idx_reg + 4'h1);
				data_next = byte_at(ev_reg, 4'(idx_reg + 4'h1));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_reg   <= '0;
			idx_reg  <= 4'h0;
			len_reg  <= 4'h0;
			act_reg  <= 1'b0;
			data_reg <= 8'h00;
			done_reg <= 1'b0;
		end else if (pce) begin
			ev_reg   <= ev_next;
			idx_reg  <= idx_next;
			len_reg  <= len_next;
			act_reg  <= act_next;
			data_reg <= data_next;
			done_reg <= done_next;
		end
	end

	assign ev_valid = act_reg;
	assign ev_data  = data_reg;
	assign busy     = act_reg;
	assign done     = done_reg;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sub_byte: assert property (
		ev_valid && ev_ready && pce && idx_reg == 4'h1 |=> ev_data == ev_reg.sub)
		else $error("sub-class byte wrong");
	a_offset_byte: assert property (
		ev_valid && ev_ready && pce && idx_reg == 4'h2
		&& ev_reg.sub == emsz_pkg::SC_SENSOR_STATE |=> ev_data[7:3] == 5'h00)
		else $error("member byte out of range");
	a_numeric_len: assert property (
		!act_reg && start && pce && ev.sub == emsz_pkg::SC_NUMERIC
		|=> len_reg == 4'(4'h6 + emsz_pkg::rd_bytes(ev_reg.dsize)))
		else $error("numeric record lacks reading");
	c_numeric: cover property (done && ev_reg.sub == emsz_pkg::SC_NUMERIC);
endmodule : emsz_fmt

/* File: sim/emsz_sink.sv */
/*
 * emsz_sink: event byte sink standing for the message transport.
 * Assumes bytes arrive with valid/ready on pclk; slow makes it stall.
 */
`timescale 1ns/10ps
module emsz_sink (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       slow,
	input  wire logic       ev_valid,
	input  wire logic [7:0] ev_data,
	input  wire logic       poll_evt,
	output logic            ev_ready
);
	logic [7:0] got_q[$];
	int         n_poll;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_ready <= 1'b0;
			n_poll   <= 0;
		end else begin
			if (ev_valid && ev_ready) begin
				got_q.push_back(ev_data);
			end
			// oversized message is left for a later poll, no push expected
			if (poll_evt) begin
				n_poll <= n_poll + 1;
			end
			ev_ready <= slow ? !ev_ready : 1'b1;
		end
	end
endmodule : emsz_sink

/* File: sim/emsz_top_bench.sv */
/*
 * emsz_top_bench: self-checking bench for negotiation, event data and irq.
 * Assumes emsz_sink as transport and a zero-wait APB slave.
 */
`timescale 1ns/10ps
module emsz_top_bench;
	logic        pclk         = 1'b0;
	logic        presetn      = 1'b0;
	logic        pce          = 1'b1;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic [31:0] pwdata       = 32'h0000_0000;
	logic        slow         = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ev_valid;
	logic [7:0]  ev_data;
	logic        ev_ready;
	logic        poll_evt;
	logic [15:0] neg_size;
	logic        irq;
	logic [31:0] rv;
	logic        perr;
	logic [15:0] rx[3]        = '{16'h0080, 16'h0800, 16'h0200};
	logic [15:0] tx[3]        = '{16'h0400, 16'h0400, 16'h0200};
	logic [15:0] lo;
	int          n_fail       = 0;
	int          total_checks = 0;

	always #10 pclk = ~pclk;

	emsz_top dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ev_valid, .ev_data, .ev_ready, .poll_evt, .neg_size, .irq);

	emsz_sink sink (.pclk, .presetn, .slow, .ev_valid, .ev_data, .poll_evt, .ev_ready);

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// one APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		rv      = prdata;
		perr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rv, exp);
	endtask : rd

	task automatic chk_irq(input logic exp);
		@(negedge pclk);
		check({31'h0, irq}, {31'h0, exp});
	endtask : chk_irq

	// emit one event and compare the stream, or the poll notice when oversized
	task automatic ev(input logic [31:0] sen, input logic [31:0] st, input logic [31:0] rdv,
			input logic [15:0] base, input logic [15:0] lim);
		logic [7:0] e[$];
		logic [1:0] sc;
		int         nb;
		int         np;
		int         k;
		sc = (sen[17:16] == 2'd3) ? 2'd0 : sen[17:16];
		e = '{sen[7:0], sen[15:8], {6'h0, sc}};
		if (sc == 2'd1) begin
			e.push_back({5'h0, sen[26:24]});
		end
		e.push_back(st[7:0]);
		e.push_back(st[24] ? st[15:8] : st[7:0]);
		if (sc == 2'd2) begin
			e.push_back(st[23:16]);
			nb = (st[23:16] < 8'h02) ? 1 : (st[23:16] < 8'h04) ? 2 : 4;
			for (int i = 0; i < nb; i++) begin
				e.push_back(rdv[8*i +: 8]);
			end
		end
		np = sink.n_poll;
		sink.got_q.delete();
		wr(emsz_pkg::A_BASE, {16'h0, base});
		wr(emsz_pkg::A_SENSOR, sen);
		wr(emsz_pkg::A_STATE, st);
		wr(emsz_pkg::A_READ, rdv);
		wr(emsz_pkg::A_STAT, 32'h0000_0007);
		wr(emsz_pkg::A_CTRL, 32'h0000_0002);
		for (k = 0; k < 100; k++) begin
			apb(1'b0, emsz_pkg::A_STAT, 32'h0000_0000);
			if ((rv & 32'h0000_0006) != 0) break;
		end
		if (k == 100) begin
			n_fail++;
			give_verdict();
		end
		if (32'(e.size()) + 32'(base) > 32'(lim)) begin
			check(rv & 32'h6, 32'h0000_0004);
			check(32'(sink.got_q.size()), 32'h0);
			check(32'(sink.n_poll), 32'(np + 1));
		end else begin
			check(32'(sink.got_q.size()), 32'(e.size()));
			for (int i = 0; i < e.size(); i++) begin
				check({24'h0, sink.got_q[i]}, {24'h0, e[i]});
			end
		end
	endtask : ev

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check({16'h0, neg_size}, 32'h0000_0100);
		rd(emsz_pkg::A_RXSIZE, 32'h0000_0100);
		rd(emsz_pkg::A_TXMAX, 32'h0000_0400);
		rd(emsz_pkg::A_STATUS, 32'h0000_0400);
		rd(8'h2C, 32'h0000_0000);
		check({31'h0, perr}, 32'h1);
		rd(8'h02, 32'h0000_0000);
		check({31'h0, perr}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			lo = (rx[i] < tx[i]) ? rx[i] : tx[i];
			wr(emsz_pkg::A_RXSIZE, {16'h0, rx[i]});
			wr(emsz_pkg::A_TXMAX, {16'h0, tx[i]});
			wr(emsz_pkg::A_CTRL, 32'h0000_0001);
			rd(emsz_pkg::A_STATUS, {14'h0, lo, 2'b01});
			rd(emsz_pkg::A_RESP, {8'h00, tx[i], 8'h00});
			check({16'h0, neg_size}, {16'h0, lo});
		end
		wr(emsz_pkg::A_MASK, 32'h0000_0006);
		chk_irq(1'b0);
		wr(emsz_pkg::A_MASK, 32'h0000_0001);
		chk_irq(1'b1);
		wr(emsz_pkg::A_STAT, 32'h0000_0001);
		chk_irq(1'b0);
		rd(emsz_pkg::A_MASK, 32'h0000_0001);
		wr(emsz_pkg::A_MASK, 32'h0000_0006);
		ev(32'h0000_A55A, 32'h0100_3344, 32'h0, 16'h0, 16'h0200);
		chk_irq(1'b1);
		slow <= 1'b1;
		ev(32'h0701_1234, 32'h0000_2211, 32'h0, 16'h0, 16'h0200);
		ev(32'h0003_00FF, 32'h0100_0506, 32'h0, 16'h0, 16'h0200);
		for (int d = 0; d < 6; d += 2) begin
			ev(32'h0002_BEEF, {8'h01, 8'(d), 16'h0709}, 32'hC3B2_A190, 16'h0, 16'h0200);
		end
		slow <= 1'b0;
		wr(emsz_pkg::A_RXSIZE, 32'h0000_0006);
		wr(emsz_pkg::A_CTRL, 32'h0000_0001);
		ev(32'h0000_0102, 32'h0000_0201, 32'h0, 16'h0, 16'h0006);
		ev(32'h0001_0102, 32'h0000_0201, 32'h0, 16'h0, 16'h0006);
		ev(32'h0002_0102, 32'h0000_0201, 32'h5, 16'h0, 16'h0006);
		ev(32'h0000_0102, 32'h0000_0201, 32'h0, 16'h1, 16'h0006);
		ev(32'h0001_0102, 32'h0000_0201, 32'h0, 16'h1, 16'h0006);
		// a write while the clock enable is low must not be stored
		pce <= 1'b0;
		wr(emsz_pkg::A_BASE, 32'h0000_0055);
		pce <= 1'b1;
		rd(emsz_pkg::A_BASE, 32'h0000_0001);
		give_verdict();
	end
endmodule : emsz_top_bench
